// ==== rtl/scp_pkg.sv ====
package scp_pkg;

  // Register map, byte addresses on the AXI4-Lite bus
  localparam int unsigned ADDR_W        = 8;
  localparam logic [7:0]  CLKCTL_OFFSET = 8'hd8;
  localparam logic [7:0]  STATUS_OFFSET = 8'hdc;
  localparam logic [7:0]  CLKCTL_RESET  = 8'h00;

  // Control register field positions
  localparam int unsigned FCT_BIT  = 7;  // fast_clock_type
  localparam int unsigned FSS_BIT  = 6;  // fast sub-clock source select
  localparam int unsigned FSEL_BIT = 5;  // fast_clock_select
  localparam int unsigned SOT_BIT  = 4;  // slow_osc_type
  localparam int unsigned STOP_BIT = 3;  // fast_osc_stop
  localparam int unsigned PSC_MSB  = 2;  // sysclk_prescale
  localparam int unsigned PSC_LSB  = 0;

  // Status register field positions
  localparam int unsigned STAT_FAST_BIT  = 0;
  localparam int unsigned STAT_HALT_BIT  = 1;
  localparam int unsigned STAT_XPIN_BIT  = 2;
  localparam int unsigned STAT_RFC_BIT   = 3;
  localparam int unsigned STAT_PSC_LSB   = 4;

  // Prescaler codes
  localparam logic [2:0] PSC_DIV32 = 3'h0;
  localparam logic [2:0] PSC_DIV16 = 3'h1;
  localparam logic [2:0] PSC_DIV8  = 3'h2;
  localparam logic [2:0] PSC_DIV4  = 3'h3;
  localparam logic [2:0] PSC_DIV2  = 3'h4;
  localparam logic [2:0] PSC_DIV1  = 3'h5;

  // Division ratios
  localparam logic [5:0] RATIO_32 = 6'h20;
  localparam logic [5:0] RATIO_16 = 6'h10;
  localparam logic [5:0] RATIO_8  = 6'h08;
  localparam logic [5:0] RATIO_4  = 6'h04;
  localparam logic [5:0] RATIO_2  = 6'h02;
  localparam logic [5:0] RATIO_1  = 6'h01;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {WR_IDLE, WR_ADDR, WR_DATA, WR_RESP} scp_wr_state_t;
  typedef enum logic       {RD_IDLE, RD_RESP} scp_rd_state_t;

endpackage

// ==== rtl/scp_osc_edge.sv ====
`timescale 1ns/1ps
module scp_osc_edge (
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic osc_in,
  output logic      tick_out
);
  logic meta_q, meta_d;
  logic sync_q, sync_d;
  logic prev_q, prev_d;
  logic tick_q, tick_d;

  // Two-stage synchroniser, then rising edge detect on the second stage
  always_comb begin
    meta_d = osc_in;
    sync_d = meta_q;
    prev_d = sync_q;
    tick_d = sync_q & ~prev_q;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
      tick_q <= 1'b0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      prev_q <= prev_d;
      tick_q <= tick_d;
    end
  end

  assign tick_out = tick_q;
endmodule

// ==== rtl/scp_prescale.sv ====
`timescale 1ns/1ps
module scp_prescale (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       tick_in,
  input  wire logic [2:0] code_in,
  output logic            pulse_out,
  output logic [5:0]      ratio_out
);
  logic [4:0] cnt_q,   cnt_d;
  logic [2:0] code_q,  code_d;
  logic       pulse_q, pulse_d;
  logic [5:0] ratio;

  // Ratio for each code; unused codes pass the clock undivided
  always_comb begin
    unique case (code_in)
      scp_pkg::PSC_DIV32: ratio = scp_pkg::RATIO_32;  // [R06]
      scp_pkg::PSC_DIV16: ratio = scp_pkg::RATIO_16;  // [R07]
      scp_pkg::PSC_DIV8:  ratio = scp_pkg::RATIO_8;   // [R12]
      scp_pkg::PSC_DIV4:  ratio = scp_pkg::RATIO_4;   // [R12]
      scp_pkg::PSC_DIV2:  ratio = scp_pkg::RATIO_2;   // [R08]
      default:            ratio = scp_pkg::RATIO_1;   // [R09]
    endcase
  end

  // Count source ticks; restart cleanly when the code changes
  always_comb begin
    code_d  = code_in;
    cnt_d   = cnt_q;
    pulse_d = 1'b0;
    if (code_in != code_q) begin
      cnt_d = 5'h00;
    end else if (tick_in) begin
      if ({1'b0, cnt_q} >= ratio - 6'h01) begin
        cnt_d   = 5'h00;
        pulse_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 5'h01;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cnt_q   <= 5'h00;
      code_q  <= 3'h0;
      pulse_q <= 1'b0;
    end else begin
      cnt_q   <= cnt_d;
      code_q  <= code_d;
      pulse_q <= pulse_d;
    end
  end

  assign pulse_out = pulse_q;
  assign ratio_out = ratio;
endmodule

// ==== rtl/scp_clock_ctrl.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// R01 - Select bit 0 slow, 1 fast
// R02 - Slow type writable only while running fast
// R03 - Slow type: 0 RC, 1 crystal pins
// R04 - Stop bit halts fast crystal and RC
// R05 - Stop bit writable in slow or feedback mode
// R06 - Prescale 000 divides by 32
// R07 - Prescale 001 divides by 16
// R08 - Prescale 100 divides by 2
// R09 - Prescale 101 passes clock undivided
// R10 - Fast type 0 uses fast sub-clock
// R11 - Software sets up feedback oscillator first
// R12 - Prescale 010 by 8, 011 by 4
module scp_clock_ctrl (
  input  wire logic        CLK_IN,
  input  wire logic        RST_IN,
  input  wire logic [7:0]  S_AXI_AWADDR_IN,
  input  wire logic        S_AXI_AWVALID_IN,
  output logic             S_AXI_AWREADY_OUT,
  input  wire logic [31:0] S_AXI_WDATA_IN,
  input  wire logic [3:0]  S_AXI_WSTRB_IN,
  input  wire logic        S_AXI_WVALID_IN,
  output logic             S_AXI_WREADY_OUT,
  output logic [1:0]       S_AXI_BRESP_OUT,
  output logic             S_AXI_BVALID_OUT,
  input  wire logic        S_AXI_BREADY_IN,
  input  wire logic [7:0]  S_AXI_ARADDR_IN,
  input  wire logic        S_AXI_ARVALID_IN,
  output logic             S_AXI_ARREADY_OUT,
  output logic [31:0]      S_AXI_RDATA_OUT,
  output logic [1:0]       S_AXI_RRESP_OUT,
  output logic             S_AXI_RVALID_OUT,
  input  wire logic        S_AXI_RREADY_IN,
  input  wire logic        SLOW_RC_OSC_IN,
  input  wire logic        SLOW_CRYSTAL_OSC_IN,
  input  wire logic        FAST_RC_OSC_IN,
  input  wire logic        FAST_CRYSTAL_OSC_IN,
  input  wire logic        RC_FEEDBACK_OSC_IN,
  output logic             SYSCLK_EN_OUT,
  output logic             FAST_OSC_ENABLE_OUT,
  output logic             SLOW_XTAL_PINS_OUT,
  output logic             SYS_ON_FAST_OUT
);
  localparam int unsigned NOSC = 5;

  logic [NOSC-1:0]     osc_pin;
  logic [NOSC-1:0]     osc_tick;
  logic [7:0]          ctl_q, ctl_d;
  scp_pkg::scp_wr_state_t wr_q, wr_d;
  scp_pkg::scp_rd_state_t rd_q, rd_d;
  logic [7:0]          waddr_q, waddr_d;
  logic [31:0]         wdata_q, wdata_d;
  logic [3:0]          wstrb_q, wstrb_d;
  logic                awrdy_q, awrdy_d;
  logic                wrdy_q, wrdy_d;
  logic                bvalid_q, bvalid_d;
  logic [1:0]          bresp_q, bresp_d;
  logic                arrdy_q, arrdy_d;
  logic                rvalid_q, rvalid_d;
  logic [1:0]          rresp_q, rresp_d;
  logic [31:0]         rdata_q, rdata_d;
  logic                ctl_wr;
  logic                fast_en_q, fast_en_d;
  logic                xpins_q, xpins_d;
  logic                onfast_q, onfast_d;
  logic                slow_tick, fsub_tick, fast_tick, sel_tick;
  logic                sysclk_pulse;
  logic [5:0]          ratio;
  logic [7:0]          status;

  // Oscillator pins enter through synchronisers, one edge detector each
  assign osc_pin = {RC_FEEDBACK_OSC_IN, FAST_CRYSTAL_OSC_IN, FAST_RC_OSC_IN,
                    SLOW_CRYSTAL_OSC_IN, SLOW_RC_OSC_IN};

  for (genvar i = 0; i < NOSC; i++) begin : g_osc
    scp_osc_edge u_edge (
      .clk_in   (CLK_IN),
      .rst_in   (RST_IN),
      .osc_in   (osc_pin[i]),
      .tick_out (osc_tick[i])
    );
  end

  // Source selection tree
  always_comb begin
    slow_tick = ctl_q[scp_pkg::SOT_BIT] ? osc_tick[1] : osc_tick[0];    // [R03]
    fsub_tick = ctl_q[scp_pkg::FSS_BIT] ? osc_tick[3] : osc_tick[2];
    fsub_tick = fsub_tick & ~ctl_q[scp_pkg::STOP_BIT];                  // [R04]
    fast_tick = ctl_q[scp_pkg::FCT_BIT] ? osc_tick[4] : fsub_tick;      // [R10]
    sel_tick  = ctl_q[scp_pkg::FSEL_BIT] ? fast_tick : slow_tick;       // [R01]
  end

  // Divider producing the system clock enable
  scp_prescale u_psc (
    .clk_in    (CLK_IN),
    .rst_in    (RST_IN),
    .tick_in   (sel_tick),
    .code_in   (ctl_q[scp_pkg::PSC_MSB:scp_pkg::PSC_LSB]),
    .pulse_out (sysclk_pulse),
    .ratio_out (ratio)
  );

  // Write channel: address and data taken in either order
  always_comb begin
    wr_d     = wr_q;
    waddr_d  = waddr_q;
    wdata_d  = wdata_q;
    wstrb_d  = wstrb_q;
    awrdy_d  = awrdy_q;
    wrdy_d   = wrdy_q;
    bvalid_d = bvalid_q;
    bresp_d  = bresp_q;
    ctl_wr   = 1'b0;
    unique case (wr_q)
      scp_pkg::WR_IDLE: begin
        if (S_AXI_AWVALID_IN && awrdy_q) begin
          waddr_d = S_AXI_AWADDR_IN;
          awrdy_d = 1'b0;
        end
        if (S_AXI_WVALID_IN && wrdy_q) begin
          wdata_d = S_AXI_WDATA_IN;
          wstrb_d = S_AXI_WSTRB_IN;
          wrdy_d  = 1'b0;
        end
        if (S_AXI_AWVALID_IN && S_AXI_WVALID_IN) begin
          wr_d = scp_pkg::WR_RESP;
        end else if (S_AXI_AWVALID_IN) begin
          wr_d = scp_pkg::WR_ADDR;
        end else if (S_AXI_WVALID_IN) begin
          wr_d = scp_pkg::WR_DATA;
        end
      end
      scp_pkg::WR_ADDR: begin
        if (S_AXI_WVALID_IN) begin
          wdata_d = S_AXI_WDATA_IN;
          wstrb_d = S_AXI_WSTRB_IN;
          wrdy_d  = 1'b0;
          wr_d    = scp_pkg::WR_RESP;
        end
      end
      scp_pkg::WR_DATA: begin
        if (S_AXI_AWVALID_IN) begin
          waddr_d = S_AXI_AWADDR_IN;
          awrdy_d = 1'b0;
          wr_d    = scp_pkg::WR_RESP;
        end
      end
      scp_pkg::WR_RESP: begin
        if (!bvalid_q) begin
          ctl_wr   = (waddr_q == scp_pkg::CLKCTL_OFFSET) && wstrb_q[0];
          bvalid_d = 1'b1;
          bresp_d  = (waddr_q == scp_pkg::CLKCTL_OFFSET ||
                      waddr_q == scp_pkg::STATUS_OFFSET) ? scp_pkg::RESP_OKAY
                                                         : scp_pkg::RESP_SLVERR;
        end else if (S_AXI_BREADY_IN) begin
          bvalid_d = 1'b0;
          awrdy_d  = 1'b1;
          wrdy_d   = 1'b1;
          wr_d     = scp_pkg::WR_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      wr_q     <= scp_pkg::WR_IDLE;
      waddr_q  <= 8'h00;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
      awrdy_q  <= 1'b1;
      wrdy_q   <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q  <= scp_pkg::RESP_OKAY;
    end else begin
      wr_q     <= wr_d;
      waddr_q  <= waddr_d;
      wdata_q  <= wdata_d;
      wstrb_q  <= wstrb_d;
      awrdy_q  <= awrdy_d;
      wrdy_q   <= wrdy_d;
      bvalid_q <= bvalid_d;
      bresp_q  <= bresp_d;
    end
  end

  // Control register update with per-bit write locks
  always_comb begin
    ctl_d = ctl_q;
    if (ctl_wr) begin
      ctl_d[scp_pkg::FCT_BIT]  = wdata_q[scp_pkg::FCT_BIT];
      ctl_d[scp_pkg::FSS_BIT]  = wdata_q[scp_pkg::FSS_BIT];
      ctl_d[scp_pkg::FSEL_BIT] = wdata_q[scp_pkg::FSEL_BIT];
      ctl_d[scp_pkg::PSC_MSB:scp_pkg::PSC_LSB] =
        wdata_q[scp_pkg::PSC_MSB:scp_pkg::PSC_LSB];
      if (ctl_q[scp_pkg::FSEL_BIT]) begin                               // [R02]
        ctl_d[scp_pkg::SOT_BIT] = wdata_q[scp_pkg::SOT_BIT];
      end
      if (!ctl_q[scp_pkg::FSEL_BIT] || ctl_q[scp_pkg::FCT_BIT]) begin   // [R05]
        ctl_d[scp_pkg::STOP_BIT] = wdata_q[scp_pkg::STOP_BIT];
      end
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      ctl_q <= scp_pkg::CLKCTL_RESET;
    end else begin
      ctl_q <= ctl_d;
    end
  end

  // Status view of the running clock tree
  always_comb begin
    status = 8'h00;
    status[scp_pkg::STAT_FAST_BIT] = onfast_q;
    status[scp_pkg::STAT_HALT_BIT] = ~fast_en_q;
    status[scp_pkg::STAT_XPIN_BIT] = xpins_q;
    status[scp_pkg::STAT_RFC_BIT]  = ctl_q[scp_pkg::FCT_BIT];
    status[scp_pkg::STAT_PSC_LSB +: 3] = ctl_q[scp_pkg::PSC_MSB:scp_pkg::PSC_LSB];
  end

  // Read channel: data one cycle after the address is taken
  always_comb begin
    rd_d     = rd_q;
    arrdy_d  = arrdy_q;
    rvalid_d = rvalid_q;
    rresp_d  = rresp_q;
    rdata_d  = rdata_q;
    unique case (rd_q)
      scp_pkg::RD_IDLE: begin
        if (S_AXI_ARVALID_IN) begin
          arrdy_d  = 1'b0;
          rvalid_d = 1'b1;
          rd_d     = scp_pkg::RD_RESP;
          rresp_d  = scp_pkg::RESP_OKAY;
          if (S_AXI_ARADDR_IN == scp_pkg::CLKCTL_OFFSET) begin
            rdata_d = {24'h00_0000, ctl_q};
          end else if (S_AXI_ARADDR_IN == scp_pkg::STATUS_OFFSET) begin
            rdata_d = {24'h00_0000, status};
          end else begin
            rdata_d = 32'h0000_0000;
            rresp_d = scp_pkg::RESP_SLVERR;
          end
        end
      end
      scp_pkg::RD_RESP: begin
        if (S_AXI_RREADY_IN) begin
          rvalid_d = 1'b0;
          arrdy_d  = 1'b1;
          rd_d     = scp_pkg::RD_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      rd_q     <= scp_pkg::RD_IDLE;
      arrdy_q  <= 1'b1;
      rvalid_q <= 1'b0;
      rresp_q  <= scp_pkg::RESP_OKAY;
      rdata_q  <= 32'h0000_0000;
    end else begin
      rd_q     <= rd_d;
      arrdy_q  <= arrdy_d;
      rvalid_q <= rvalid_d;
      rresp_q  <= rresp_d;
      rdata_q  <= rdata_d;
    end
  end

  // Registered control outputs toward the oscillators and pins
  always_comb begin
    fast_en_d = ~ctl_q[scp_pkg::STOP_BIT];                              // [R04]
    xpins_d   = ctl_q[scp_pkg::SOT_BIT];                                // [R03]
    onfast_d  = ctl_q[scp_pkg::FSEL_BIT];                               // [R01]
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      fast_en_q <= 1'b1;
      xpins_q   <= 1'b0;
      onfast_q  <= 1'b0;
    end else begin
      fast_en_q <= fast_en_d;
      xpins_q   <= xpins_d;
      onfast_q  <= onfast_d;
    end
  end

  assign S_AXI_AWREADY_OUT   = awrdy_q;
  assign S_AXI_WREADY_OUT    = wrdy_q;
  assign S_AXI_BVALID_OUT    = bvalid_q;
  assign S_AXI_BRESP_OUT     = bresp_q;
  assign S_AXI_ARREADY_OUT   = arrdy_q;
  assign S_AXI_RVALID_OUT    = rvalid_q;
  assign S_AXI_RRESP_OUT     = rresp_q;
  assign S_AXI_RDATA_OUT     = rdata_q;
  assign SYSCLK_EN_OUT       = sysclk_pulse;
  assign FAST_OSC_ENABLE_OUT = fast_en_q;
  assign SLOW_XTAL_PINS_OUT  = xpins_q;
  assign SYS_ON_FAST_OUT     = onfast_q;

  // Checking helpers: source ticks counted between system clock pulses
  logic [6:0] hcnt_q;
  logic [2:0] hpsc_q;
  logic       primed_q;
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      hcnt_q   <= 7'h00;
      hpsc_q   <= 3'h0;
      primed_q <= 1'b0;
    end else begin
      hpsc_q <= ctl_q[scp_pkg::PSC_MSB:scp_pkg::PSC_LSB];
      if (ctl_q[scp_pkg::PSC_MSB:scp_pkg::PSC_LSB] != hpsc_q) begin
        hcnt_q   <= 7'h00;
        primed_q <= 1'b0;
      end else if (sysclk_pulse) begin
        hcnt_q   <= {6'h00, sel_tick};
        primed_q <= 1'b1;
      end else begin
        hcnt_q <= hcnt_q + {6'h00, sel_tick};
      end
    end
  end

  sequence s_ctl_write;
    ctl_wr;
  endsequence

  sequence s_div_edge(logic [2:0] code);
    primed_q && sysclk_pulse && hpsc_q == code &&
    ctl_q[scp_pkg::PSC_MSB:scp_pkg::PSC_LSB] == code;
  endsequence

  AST_FAST_PATH: assert property (@(posedge CLK_IN) disable iff (RST_IN) // [R01]
    ctl_q[scp_pkg::FSEL_BIT] && ctl_q[scp_pkg::FCT_BIT] && osc_tick[4] |-> sel_tick)
    else $error("fast source tick not selected");
  AST_SLOW_TYPE_LOCK: assert property (@(posedge CLK_IN) disable iff (RST_IN) // [R02]
    s_ctl_write ##0 !ctl_q[scp_pkg::FSEL_BIT] |=> $stable(ctl_q[scp_pkg::SOT_BIT]))
    else $error("slow type changed while running slow");
  AST_XTAL_PINS: assert property (@(posedge CLK_IN) disable iff (RST_IN) // [R03]
    $rose(ctl_q[scp_pkg::SOT_BIT]) |=> SLOW_XTAL_PINS_OUT ##0 status[scp_pkg::STAT_XPIN_BIT])
    else $error("crystal pins not claimed");
  AST_FAST_HALT: assert property (@(posedge CLK_IN) disable iff (RST_IN) // [R04]
    ctl_q[scp_pkg::STOP_BIT] && !ctl_q[scp_pkg::FCT_BIT] |-> !fast_tick ##1 !FAST_OSC_ENABLE_OUT)
    else $error("fast oscillators not halted");
  AST_STOP_LOCK: assert property (@(posedge CLK_IN) disable iff (RST_IN) // [R05]
    s_ctl_write ##0 ctl_q[scp_pkg::FSEL_BIT] && !ctl_q[scp_pkg::FCT_BIT]
    |=> $stable(ctl_q[scp_pkg::STOP_BIT]))
    else $error("stop bit changed in fast sub-clock mode");
  AST_DIV32: assert property (@(posedge CLK_IN) disable iff (RST_IN) // [R06]
    s_div_edge(scp_pkg::PSC_DIV32) |-> hcnt_q == 7'h20)
    else $error("divide by 32 wrong");
  AST_DIV16: assert property (@(posedge CLK_IN) disable iff (RST_IN) // [R07]
    s_div_edge(scp_pkg::PSC_DIV16) |-> hcnt_q == 7'h10)
    else $error("divide by 16 wrong");
  AST_DIV2: assert property (@(posedge CLK_IN) disable iff (RST_IN) // [R08]
    s_div_edge(scp_pkg::PSC_DIV2) |-> hcnt_q == 7'h02)
    else $error("divide by 2 wrong");
  AST_DIV1: assert property (@(posedge CLK_IN) disable iff (RST_IN) // [R09]
    sel_tick && ctl_q[scp_pkg::PSC_MSB:scp_pkg::PSC_LSB] == scp_pkg::PSC_DIV1
    && $stable(ctl_q) |=> SYSCLK_EN_OUT)
    else $error("undivided clock missed a tick");
  AST_FAST_SUB: assert property (@(posedge CLK_IN) disable iff (RST_IN) // [R10]
    ctl_q[scp_pkg::FSEL_BIT] && !ctl_q[scp_pkg::FCT_BIT] && !ctl_q[scp_pkg::STOP_BIT]
    && !ctl_q[scp_pkg::FSS_BIT] && osc_tick[2] |-> sel_tick)
    else $error("fast sub-clock tick not selected");
  AST_DIV8_4: assert property (@(posedge CLK_IN) disable iff (RST_IN) // [R12]
    (s_div_edge(scp_pkg::PSC_DIV8) |-> hcnt_q == 7'h08) and
    (s_div_edge(scp_pkg::PSC_DIV4) |-> hcnt_q == 7'h04))
    else $error("divide by 8 or 4 wrong");
endmodule

// ==== dv/scp_clock_ctrl_tb.sv ====
`timescale 1ns/1ps
module scp_clock_ctrl_tb;
  // One comparison: count it, report and count a mismatch
  `define CHECK_EQ(nm, e, g) begin checks_done++; if ((g) !== (e)) begin err_count++; \
    $display("[FAIL] %s expected %0h seen %0h", nm, (e), (g)); end end

  logic        clk_in;
  logic        rst_in;
  logic [7:0]  awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [7:0]  araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic [4:0]  osc;
  logic        sysclk_en;
  logic        fast_en;
  logic        xtal_pins;
  logic        on_fast;
  logic [7:0]  ctl;
  int          err_count;
  int          checks_done;
  int          cycles;
  int          half [5] = '{2, 6, 3, 4, 5};
  int          cnt [5];

  scp_clock_ctrl dut (
    .CLK_IN              (clk_in),
    .RST_IN              (rst_in),
    .S_AXI_AWADDR_IN     (awaddr),
    .S_AXI_AWVALID_IN    (awvalid),
    .S_AXI_AWREADY_OUT   (awready),
    .S_AXI_WDATA_IN      (wdata),
    .S_AXI_WSTRB_IN      (wstrb),
    .S_AXI_WVALID_IN     (wvalid),
    .S_AXI_WREADY_OUT    (wready),
    .S_AXI_BRESP_OUT     (bresp),
    .S_AXI_BVALID_OUT    (bvalid),
    .S_AXI_BREADY_IN     (bready),
    .S_AXI_ARADDR_IN     (araddr),
    .S_AXI_ARVALID_IN    (arvalid),
    .S_AXI_ARREADY_OUT   (arready),
    .S_AXI_RDATA_OUT     (rdata),
    .S_AXI_RRESP_OUT     (rresp),
    .S_AXI_RVALID_OUT    (rvalid),
    .S_AXI_RREADY_IN     (rready),
    .SLOW_RC_OSC_IN      (osc[0]),
    .SLOW_CRYSTAL_OSC_IN (osc[1]),
    .FAST_RC_OSC_IN      (osc[2]),
    .FAST_CRYSTAL_OSC_IN (osc[3]),
    .RC_FEEDBACK_OSC_IN  (osc[4]),
    .SYSCLK_EN_OUT       (sysclk_en),
    .FAST_OSC_ENABLE_OUT (fast_en),
    .SLOW_XTAL_PINS_OUT  (xtal_pins),
    .SYS_ON_FAST_OUT     (on_fast)
  );

  // Clock, 8 ns period
  initial clk_in = 1'b0;
  always #4 clk_in = ~clk_in;

  // Oscillators with periods 4, 12, 6, 8 and 10 clock cycles
  always @(posedge clk_in) begin
    for (int i = 0; i < 5; i++) begin
      if (cnt[i] + 1 >= half[i]) begin
        cnt[i] = 0;
        osc[i] <= ~osc[i];
      end else begin
        cnt[i] = cnt[i] + 1;
      end
    end
  end

  // Hang guard
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 90000) begin
      err_count++;
      $display("[FAIL] cycle limit expected below 90000 seen 90000");
      complete_run();
    end
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Control register after a write, with the mode locks applied
  function automatic logic [7:0] next_ctl(logic [7:0] c, logic [7:0] v, logic [3:0] s);
    logic [7:0] n;
    if (!s[0]) return c;
    n = v;
    if (!c[5]) n[4] = c[4];
    if (c[5] && !c[7]) n[3] = c[3];
    return n;
  endfunction

  // Source period in clock cycles, 0 when the source is halted
  function automatic int src_period(logic [7:0] c);
    if (!c[5]) return c[4] ? 12 : 4;
    if (c[7]) return 10;
    if (c[3]) return 0;
    return c[6] ? 8 : 6;
  endfunction

  function automatic int ratio(logic [2:0] p);
    case (p)
      3'h0: return 32;
      3'h1: return 16;
      3'h2: return 8;
      3'h3: return 4;
      3'h4: return 2;
      default: return 1;
    endcase
  endfunction

  // AXI4-Lite write, address and data offered together
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                           output logic [1:0] r);
    int n;
    n = 0;
    r = 2'h3;
    @(posedge clk_in);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (n < 300) begin
      @(posedge clk_in);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bready && bvalid) begin
        r = bresp;
        bready <= 1'b0;
        n = 1000;
      end
    end
    `CHECK_EQ("write handshake", 1'b1, (n != 300))
  endtask

  // AXI4-Lite read
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    d = '1;
    r = 2'h3;
    @(posedge clk_in);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (n < 300) begin
      @(posedge clk_in);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rready && rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        n = 1000;
      end
    end
    `CHECK_EQ("read handshake", 1'b1, (n != 300))
  endtask

  // Cycles between two enable pulses, 0 when none come
  task automatic measure(output int c);
    int n;
    n = 0;
    c = 0;
    while (n < 1500 && sysclk_en !== 1'b1) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    if (n < 1500) begin
      do begin
        @(posedge clk_in);
        #1;
        c++;
      end while (sysclk_en !== 1'b1 && c < 1500);
      if (c == 1500) c = 0;
    end
  endtask

  // Write the control register, then check readback and mode levels
  task automatic wr_ctl(input logic [31:0] v, input logic [3:0] s);
    logic [1:0]  r;
    logic [31:0] d;
    axi_write(scp_pkg::CLKCTL_OFFSET, v, s, r);
    ctl = next_ctl(ctl, v[7:0], s);
    `CHECK_EQ("write resp", scp_pkg::RESP_OKAY, r)
    // Status view: prescale, feedback, crystal pins, halted, on fast
    axi_read(scp_pkg::STATUS_OFFSET, d, r);
    `CHECK_EQ("status", {25'h0, ctl[2:0], ctl[7], ctl[4], ctl[3], ctl[5]}, d)
    axi_read(scp_pkg::CLKCTL_OFFSET, d, r);
    #1;
    `CHECK_EQ("ctl readback", {24'h0, ctl}, d)
    `CHECK_EQ("on fast", ctl[5], on_fast)
    `CHECK_EQ("fast enable", ~ctl[3], fast_en)
    `CHECK_EQ("xtal pins", ctl[4], xtal_pins)
  endtask

  // Set a mode and measure the enable pulse spacing
  task automatic probe(input logic [7:0] v);
    int c;
    wr_ctl({24'h0, v}, 4'h1);
    measure(c);
    `CHECK_EQ("interval", ratio(ctl[2:0]) * src_period(ctl), c)
  endtask

  // Main sequence
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    int          c;
    void'($urandom(32'h480dcd61));
    rst_in  = 1'b1;
    osc     = 5'h00;
    awaddr  = 8'h00;
    awvalid = 1'b0;
    wdata   = 32'h0;
    wstrb   = 4'h0;
    wvalid  = 1'b0;
    bready  = 1'b0;
    araddr  = 8'h00;
    arvalid = 1'b0;
    rready  = 1'b0;
    ctl     = scp_pkg::CLKCTL_RESET;
    repeat (5) @(posedge clk_in);
    rst_in <= 1'b0;
    #1;
    `CHECK_EQ("reset on fast", 1'b0, on_fast)
    `CHECK_EQ("reset fast enable", 1'b1, fast_en)
    axi_read(scp_pkg::CLKCTL_OFFSET, d, r);
    #1;
    `CHECK_EQ("reset ctl", 32'h0, d)
    measure(c);
    `CHECK_EQ("reset interval", 128, c)
    $display("test reset done");
    // Every prescale code on the slow RC source, then each fast source
    for (int i = 0; i < 8; i++) probe(8'(i));
    probe(8'h25);
    probe(8'h63);
    probe(8'ha2);
    probe(8'h05);
    $display("test sources done");
    // Mode locks and oscillator stop
    probe(8'h15);
    probe(8'h35);
    probe(8'h3d);
    probe(8'h15);
    probe(8'h1d);
    probe(8'h3d);
    probe(8'hbd);
    probe(8'hb5);
    $display("test locks done");
    // Unmapped and read-only places
    axi_write(8'h40, 32'hff, 4'hf, r);
    `CHECK_EQ("unmapped write resp", scp_pkg::RESP_SLVERR, r)
    axi_read(8'h40, d, r);
    `CHECK_EQ("unmapped read resp", scp_pkg::RESP_SLVERR, r)
    `CHECK_EQ("unmapped read data", 32'h0, d)
    axi_write(scp_pkg::STATUS_OFFSET, 32'hff, 4'hf, r);
    `CHECK_EQ("status write resp", scp_pkg::RESP_OKAY, r)
    axi_read(scp_pkg::CLKCTL_OFFSET, d, r);
    `CHECK_EQ("ctl after status write", {24'h0, ctl}, d)
    $display("test errors done");
    // Random writes with random strobes, then random modes
    repeat (24) wr_ctl($urandom, 4'($urandom));
    repeat (4) probe(8'($urandom));
    $display("test random done");
    complete_run();
  end
endmodule
